// >>> common/sensor_status_map.vh
`ifndef SENSOR_STATUS_MAP_VH
`define SENSOR_STATUS_MAP_VH
// register offsets (word addresses on the register port)
`define REG_COMM_TIMEOUT 8'h08
`define REG_TERM_ENABLE 8'h09
`define REG_LIGHT_ACTIVE 8'h23
`define REG_LIGHT_STANDBY 8'h24
`define REG_AMBIENT_LUX 8'h29
`define REG_LIGHT_STATE 8'h2A
`define REG_SOURCE_SELECT 8'h4F
`define REG_BRIGHTNESS 8'h50
// light state codes
`define LIGHT_STANDBY 16'h0000
`define LIGHT_LOW 16'h0001
`define LIGHT_ACTIVE 16'h0002
// source select value for humidity
`define SRC_HUMIDITY 16'h0001
// reset values
`define RST_TIMEOUT 16'h0000
`define RST_TERM 16'h0000
`define RST_ACTIVE 16'h01F4
`define RST_STANDBY 16'h0032
`define RST_SOURCE 16'h0000
`define RST_BRIGHT 16'h000A
// brightness is 0..10 steps of ten percent
`define BRIGHT_MAX 4'hA
// timing
`define SEC_NS 64'd1000000000
`define CLK_NS 64'd10
`define BLINK_MS 64'd250
`define NS_PER_MS 64'd1000000
`endif

// >>> hdl/brightness_pwm.v
`timescale 1ns/1ps
`include "sensor_status_map.vh"
// ten-step pwm dimmer shared by all three lamps
module brightness_pwm #(
  parameter PRESCALE = 100
) (
  input wire sys_clk,
  input wire rst,
  input wire [3:0] level,
  output reg pwm_on
);
  reg [15:0] pre_r;
  reg [3:0] slot_r;

  // slot counter walks 0..9; lamp is lit while slot is below level
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_r <= 16'h0000;
      slot_r <= 4'h0;
      pwm_on <= 1'b0;
    end else begin
      if (pre_r == PRESCALE[15:0] - 16'h0001) begin
        pre_r <= 16'h0000;
        slot_r <= (slot_r == `BRIGHT_MAX - 4'h1) ? 4'h0 : slot_r + 4'h1;
      end else begin
        pre_r <= pre_r + 16'h0001;
      end
      pwm_on <= (slot_r < level); // level 10 or more keeps it always lit
    end
  end
endmodule // brightness_pwm

// >>> hdl/room_sensor_status_indication.v
`timescale 1ns/1ps
`include "sensor_status_map.vh"
// Contract
// - green lit when selected value lies between min and max alert thresholds.
// - yellow steady while selected value is inside alert range.
// - yellow blinks when timeout nonzero and no bus traffic within it.
// - red steady when selected value is outside measurement range.
// - red blinks when an internal sensing element is lost.
// - bootloader flashes green and yellow alternately, never together.
// - firmware download in bootloader also flashes red.
// - indication uses temperature by default, humidity when selected.
// - lamp brightness zero to full in ten-percent steps from register.
// - measured ambient lux is readable in an input register.
// - master programs active and standby light thresholds used here.
// - light state reads standby when lux is below standby threshold.
// - light state reads active when lux exceeds active threshold.
// - light state reads low intensity between thresholds, both equalities included.
// - termination connects when enable set; master enables exactly two nodes.
// - analogue demand follows larger channel output; channels can be disabled.
module room_sensor_status_indication #(
  parameter BLINK_CYCLES = (`BLINK_MS * `NS_PER_MS) / `CLK_NS,
  parameter SEC_CYCLES = `SEC_NS / `CLK_NS,
  parameter PWM_PRESCALE = 100
) (
  input wire sys_clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire bus_activity,
  input wire [15:0] temperature,
  input wire [15:0] humidity_channel,
  input wire [15:0] temp_alert_min,
  input wire [15:0] temp_alert_max,
  input wire [15:0] temp_range_min,
  input wire [15:0] temp_range_max,
  input wire [15:0] hum_alert_min,
  input wire [15:0] hum_alert_max,
  input wire [15:0] hum_range_min,
  input wire [15:0] hum_range_max,
  input wire sensor_lost,
  input wire bootloader_mode,
  input wire fw_downloading,
  input wire [15:0] ambient_lux,
  input wire [15:0] temp_demand,
  input wire [15:0] hum_demand,
  input wire temp_channel_on,
  input wire hum_channel_on,
  output reg [15:0] reg_rdata,
  output reg reg_rvalid,
  output reg reg_err,
  output reg led_green,
  output reg led_yellow,
  output reg led_red,
  output reg bus_terminator_enable,
  output reg [15:0] analog_demand
);
  localparam ST_NORMAL = 4'b0001;
  localparam ST_ALERT = 4'b0010;
  localparam ST_RANGE = 4'b0100;
  localparam ST_BOOT = 4'b1000;

  reg [15:0] comm_timeout_setting_r;
  reg [15:0] termination_enable_r;
  reg [15:0] light_active_threshold_r;
  reg [15:0] light_standby_threshold_r;
  reg [15:0] indication_source_select_r;
  reg [15:0] indicator_brightness_r;
  reg [15:0] ambient_light_lux_r;
  reg [15:0] ambient_light_state_r;
  reg [15:0] light_state_nxt;
  reg [31:0] blink_cnt_r;
  reg blink_r;
  reg [31:0] sec_cnt_r;
  reg [15:0] idle_sec_r;
  reg comm_lost_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [15:0] sel_val;
  reg [15:0] sel_amin;
  reg [15:0] sel_amax;
  reg [15:0] sel_rmin;
  reg [15:0] sel_rmax;
  reg [15:0] demand_nxt;
  reg [3:0] bright_lvl;
  wire pwm_on;

  // register writes; unknown or read-only offsets are ignored
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comm_timeout_setting_r <= `RST_TIMEOUT;
      termination_enable_r <= `RST_TERM;
      light_active_threshold_r <= `RST_ACTIVE;
      light_standby_threshold_r <= `RST_STANDBY;
      indication_source_select_r <= `RST_SOURCE;
      indicator_brightness_r <= `RST_BRIGHT;
    end else if (reg_wr) begin
      if (reg_addr == `REG_COMM_TIMEOUT) begin
        comm_timeout_setting_r <= reg_wdata;
      end else if (reg_addr == `REG_TERM_ENABLE) begin
        termination_enable_r <= reg_wdata;
      end else if (reg_addr == `REG_LIGHT_ACTIVE) begin
        light_active_threshold_r <= reg_wdata;
      end else if (reg_addr == `REG_LIGHT_STANDBY) begin
        light_standby_threshold_r <= reg_wdata;
      end else if (reg_addr == `REG_SOURCE_SELECT) begin
        indication_source_select_r <= reg_wdata;
      end else if (reg_addr == `REG_BRIGHTNESS) begin
        indicator_brightness_r <= reg_wdata;
      end
    end
  end

  // register reads answer one cycle later; unmapped offsets flag an error
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_err <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_err <= 1'b0;
      if (!reg_rd) begin
        reg_rdata <= 16'h0000;
      end else if (reg_addr == `REG_COMM_TIMEOUT) begin
        reg_rdata <= comm_timeout_setting_r;
      end else if (reg_addr == `REG_TERM_ENABLE) begin
        reg_rdata <= termination_enable_r;
      end else if (reg_addr == `REG_LIGHT_ACTIVE) begin
        reg_rdata <= light_active_threshold_r;
      end else if (reg_addr == `REG_LIGHT_STANDBY) begin
        reg_rdata <= light_standby_threshold_r;
      end else if (reg_addr == `REG_AMBIENT_LUX) begin
        reg_rdata <= ambient_light_lux_r;
      end else if (reg_addr == `REG_LIGHT_STATE) begin
        reg_rdata <= ambient_light_state_r;
      end else if (reg_addr == `REG_SOURCE_SELECT) begin
        reg_rdata <= indication_source_select_r;
      end else if (reg_addr == `REG_BRIGHTNESS) begin
        reg_rdata <= indicator_brightness_r;
      end else begin
        reg_rdata <= 16'h0000;
        reg_err <= 1'b1;
      end
    end
  end

  // light classification; ties fall to low intensity so every reading is defined
  always @* begin
    if (ambient_lux < light_standby_threshold_r) begin
      light_state_nxt = `LIGHT_STANDBY;
    end else if (ambient_lux > light_active_threshold_r) begin
      light_state_nxt = `LIGHT_ACTIVE;
    end else begin
      light_state_nxt = `LIGHT_LOW;
    end
  end

  // sampled lux and state, plus termination output
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ambient_light_lux_r <= 16'h0000;
      ambient_light_state_r <= `LIGHT_STANDBY;
      bus_terminator_enable <= 1'b0;
    end else begin
      ambient_light_lux_r <= ambient_lux;
      ambient_light_state_r <= light_state_nxt;
      bus_terminator_enable <= (termination_enable_r != 16'h0000);
    end
  end

  // blink time base; shared phase keeps flashing lamps in step, bootloader yellow runs inverted
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blink_cnt_r <= 32'h00000000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYCLES - 1) begin
      blink_cnt_r <= 32'h00000000;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h00000001;
    end
  end

  // bus idle watchdog in whole seconds; any traffic restarts it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sec_cnt_r <= 32'h00000000;
      idle_sec_r <= 16'h0000;
      comm_lost_r <= 1'b0;
    end else if (bus_activity || comm_timeout_setting_r == 16'h0000) begin
      sec_cnt_r <= 32'h00000000;
      idle_sec_r <= 16'h0000;
      comm_lost_r <= 1'b0;
    end else begin
      if (sec_cnt_r >= SEC_CYCLES - 1) begin
        sec_cnt_r <= 32'h00000000;
        if (idle_sec_r != 16'hFFFF) begin
          idle_sec_r <= idle_sec_r + 16'h0001;
        end
      end else begin
        sec_cnt_r <= sec_cnt_r + 32'h00000001;
      end
      comm_lost_r <= (idle_sec_r >= comm_timeout_setting_r);
    end
  end

  // choose the quantity the lamps refer to
  always @* begin
    if (indication_source_select_r == `SRC_HUMIDITY) begin
      sel_val = humidity_channel;
      sel_amin = hum_alert_min;
      sel_amax = hum_alert_max;
      sel_rmin = hum_range_min;
      sel_rmax = hum_range_max;
    end else begin
      sel_val = temperature;
      sel_amin = temp_alert_min;
      sel_amax = temp_alert_max;
      sel_rmin = temp_range_min;
      sel_rmax = temp_range_max;
    end
  end

  // indication state; bootloader overrides measurement display
  always @* begin
    if (bootloader_mode) begin
      state_nxt = ST_BOOT;
    end else if (sel_val < sel_rmin || sel_val > sel_rmax) begin
      state_nxt = ST_RANGE;
    end else if (sel_val < sel_amin || sel_val > sel_amax) begin
      state_nxt = ST_ALERT;
    end else begin
      state_nxt = ST_NORMAL;
    end
  end

  // brightness clamps at full scale for out-of-range settings
  always @* begin
    if (indicator_brightness_r > {12'h000, `BRIGHT_MAX}) begin
      bright_lvl = `BRIGHT_MAX;
    end else begin
      bright_lvl = indicator_brightness_r[3:0];
    end
  end

  brightness_pwm #(
    .PRESCALE(PWM_PRESCALE)
  ) brightness_pwm_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .level(bright_lvl),
    .pwm_on(pwm_on)
  );

  // lamp drive; fault blinks override the steady colour of the same lamp
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_NORMAL;
      led_green <= 1'b0;
      led_yellow <= 1'b0;
      led_red <= 1'b0;
    end else begin
      state_r <= state_nxt;
      case (state_r)
        ST_BOOT: begin
          led_green <= pwm_on & blink_r;
          led_yellow <= pwm_on & ~blink_r;
          led_red <= pwm_on & fw_downloading & blink_r;
        end
        ST_RANGE: begin
          led_green <= 1'b0;
          led_yellow <= comm_lost_r & pwm_on & blink_r;
          led_red <= pwm_on & (sensor_lost ? blink_r : 1'b1);
        end
        ST_ALERT: begin
          led_green <= 1'b0;
          led_yellow <= pwm_on & (comm_lost_r ? blink_r : 1'b1);
          led_red <= sensor_lost & pwm_on & blink_r;
        end
        default: begin
          led_green <= pwm_on;
          led_yellow <= comm_lost_r & pwm_on & blink_r;
          led_red <= sensor_lost & pwm_on & blink_r;
        end
      endcase
    end
  end

  // analogue demand: larger of enabled channels
  always @* begin
    if (temp_channel_on && hum_channel_on) begin
      demand_nxt = (temp_demand > hum_demand) ? temp_demand : hum_demand;
    end else if (temp_channel_on) begin
      demand_nxt = temp_demand;
    end else if (hum_channel_on) begin
      demand_nxt = hum_demand;
    end else begin
      demand_nxt = 16'h0000;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_demand <= 16'h0000;
    end else begin
      analog_demand <= demand_nxt;
    end
  end
endmodule // room_sensor_status_indication

// >>> sim/modbus_master.sv
`timescale 1ns/1ps
// stand-in for the remote bus master; this node is one of the two terminated ones
module modbus_master (
  input wire sys_clk,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [15:0] reg_wdata,
  output reg bus_activity,
  input wire [15:0] reg_rdata,
  input wire reg_err
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 16'hFFFF;
    bus_activity = 1'b0;
  end
  // one word per frame; released lines show inverted values, not stale ones
  task xfer(input w, input [7:0] a, input [15:0] v, output [15:0] d, output e);
    begin
      @(posedge sys_clk);
      #1 reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = v;
      bus_activity = 1'b1;
      @(posedge sys_clk);
      #1 d = reg_rdata;
      e = reg_err;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~v;
      bus_activity = 1'b0;
    end
  endtask
endmodule // modbus_master

// >>> sim/room_sensor_status_indication_properties.sv
`timescale 1ns/1ps
`include "sensor_status_map.vh"
// port-side checker for the status block
module room_sensor_checker (
  input wire sys_clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] temperature,
  input wire [15:0] humidity_channel,
  input wire [15:0] temp_range_min,
  input wire [15:0] temp_range_max,
  input wire [15:0] hum_range_min,
  input wire [15:0] hum_range_max,
  input wire sensor_lost,
  input wire bootloader_mode,
  input wire [15:0] ambient_lux,
  input wire [15:0] temp_demand,
  input wire [15:0] hum_demand,
  input wire temp_channel_on,
  input wire hum_channel_on,
  input wire [15:0] reg_rdata,
  input wire reg_rvalid,
  input wire reg_err,
  input wire led_green,
  input wire led_yellow,
  input wire led_red,
  input wire bus_terminator_enable,
  input wire [15:0] analog_demand
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // expected demand; a disabled channel counts as zero
  wire [15:0] t_eff = temp_channel_on ? temp_demand : 16'h0000;
  wire [15:0] h_eff = hum_channel_on ? hum_demand : 16'h0000;
  wire [15:0] top_demand = (t_eff > h_eff) ? t_eff : h_eff;
  // both values inside range, no lost sensor, no bootloader: nothing may turn red
  wire calm = !bootloader_mode && !sensor_lost && temperature >= temp_range_min &&
    temperature <= temp_range_max && humidity_channel >= hum_range_min &&
    humidity_channel <= hum_range_max;
  sequence calm_run;
    calm [*3];
  endsequence
  sequence boot_run;
    bootloader_mode [*3];
  endsequence
  sequence term_write;
    (reg_wr && reg_addr == `REG_TERM_ENABLE) ##1 !(reg_wr && reg_addr == `REG_TERM_ENABLE);
  endsequence
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid && !reg_err && reg_rdata == 16'h0000)
    else $error("read port not idle");
  unmapped_err_a: assert property (reg_rd && reg_addr == 8'h00 |=>
    reg_err && reg_rdata == 16'h0000)
    else $error("unmapped read not flagged");
  lux_read_a: assert property (reg_rd && reg_addr == `REG_AMBIENT_LUX && !$past(rst) |=>
    reg_rdata == $past(ambient_lux, 2))
    else $error("lux register wrong");
  term_follow_a: assert property (term_write |=>
    bus_terminator_enable == ($past(reg_wdata, 2) != 16'h0000))
    else $error("terminator not following register");
  demand_max_a: assert property (1'b1 |=> analog_demand == $past(top_demand))
    else $error("demand not the larger channel");
  boot_alt_a: assert property (boot_run |-> !(led_green && led_yellow))
    else $error("green and yellow on together");
  red_calm_a: assert property (calm_run |-> !led_red)
    else $error("red lit with values in range");
endmodule // room_sensor_checker
bind room_sensor_status_indication room_sensor_checker room_sensor_checker_i (.sys_clk, .rst,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .temperature, .humidity_channel, .temp_range_min,
  .temp_range_max, .hum_range_min, .hum_range_max, .sensor_lost, .bootloader_mode,
  .ambient_lux, .temp_demand, .hum_demand, .temp_channel_on, .hum_channel_on, .reg_rdata,
  .reg_rvalid, .reg_err, .led_green, .led_yellow, .led_red, .bus_terminator_enable,
  .analog_demand);

// >>> sim/room_sensor_status_indication_tb_top.sv
`timescale 1ns/1ps
`include "sensor_status_map.vh"
module room_sensor_status_indication_tb_top;
  reg sys_clk = 1'b0, rst = 1'b1, sensor_lost = 1'b0, bootloader_mode = 1'b0;
  reg fw_downloading = 1'b0, temp_channel_on = 1'b1, hum_channel_on = 1'b1, e;
  reg [15:0] temperature = 16'h0019, humidity_channel = 16'h0032, ambient_lux = 16'h0007;
  reg [15:0] temp_alert_min = 16'h0014, temp_alert_max = 16'h001E, temp_range_min = 16'h0000;
  reg [15:0] temp_range_max = 16'h0032, hum_alert_min = 16'h0028, hum_alert_max = 16'h003C;
  reg [15:0] hum_range_min = 16'h0000, hum_range_max = 16'h0064;
  reg [15:0] temp_demand = 16'h0010, hum_demand = 16'h0020, d, cg, cy, cr, cb;
  wire reg_wr, reg_rd, bus_activity, reg_rvalid, reg_err;
  wire led_green, led_yellow, led_red, bus_terminator_enable;
  wire [7:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata, analog_demand;
  integer n_errors = 0, num_checks = 0, cyc = 0, i;
  // short counts so blink, idle second and pwm fit in a few cycles
  room_sensor_status_indication #(.BLINK_CYCLES(4), .SEC_CYCLES(10), .PWM_PRESCALE(1))
    room_sensor_status_indication_i (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .bus_activity, .temperature, .humidity_channel, .temp_alert_min,
    .temp_alert_max, .temp_range_min, .temp_range_max, .hum_alert_min, .hum_alert_max,
    .hum_range_min, .hum_range_max, .sensor_lost, .bootloader_mode, .fw_downloading,
    .ambient_lux, .temp_demand, .hum_demand, .temp_channel_on, .hum_channel_on, .reg_rdata,
    .reg_rvalid, .reg_err, .led_green, .led_yellow, .led_red, .bus_terminator_enable,
    .analog_demand);
  modbus_master modbus_master_i (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .bus_activity, .reg_rdata, .reg_err);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // hang guard, well above the two hundred or so cycles the run needs
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  task chk(input [8*6-1:0] nm, input [15:0] s, input [15:0] x);
    begin
      num_checks = num_checks + 1;
      if (s !== x) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] v);
    modbus_master_i.xfer(1'b1, a, v, d, e);
  endtask
  task rchk(input [7:0] a, input [15:0] x);
    begin
      modbus_master_i.xfer(1'b0, a, 16'h0000, d, e);
      chk("rdata", d, x);
    end
  endtask
  // lamps settle after two cycles; sample on the fourth
  task lamps(input [2:0] x);
    begin
      repeat (4) @(posedge sys_clk);
      #1 chk("lamps", {13'h0000, led_green, led_yellow, led_red}, {13'h0000, x});
    end
  endtask
  task watch(input integer n);
    begin
      cg = 0;
      cy = 0;
      cr = 0;
      cb = 0;
      repeat (n) begin
        @(posedge sys_clk);
        #1 cg = cg + led_green;
        cy = cy + led_yellow;
        cr = cr + led_red;
        cb = cb + (led_green & led_yellow);
      end
    end
  endtask
  task t_regs;
    begin
      rchk(`REG_COMM_TIMEOUT, `RST_TIMEOUT);
      rchk(`REG_TERM_ENABLE, `RST_TERM);
      rchk(`REG_LIGHT_ACTIVE, `RST_ACTIVE);
      rchk(`REG_LIGHT_STANDBY, `RST_STANDBY);
      rchk(`REG_SOURCE_SELECT, `RST_SOURCE);
      rchk(`REG_BRIGHTNESS, `RST_BRIGHT);
      wr(`REG_LIGHT_ACTIVE, 16'h0014);
      wr(`REG_LIGHT_STANDBY, 16'h000A);
      wr(`REG_AMBIENT_LUX, 16'hFFFF);
      rchk(`REG_AMBIENT_LUX, 16'h0007);
      rchk(`REG_LIGHT_ACTIVE, 16'h0014);
      rchk(8'h00, 16'h0000);
      chk("err", {15'h0000, e}, 16'h0001);
    end
  endtask
  // lux 5..25 against standby 10 and active 20, both equalities included
  task t_light;
    for (i = 0; i < 5; i = i + 1) begin
      ambient_lux = 16'h0005 + 16'h0005 * i[15:0];
      rchk(`REG_LIGHT_STATE, i == 0 ? `LIGHT_STANDBY : i == 4 ? `LIGHT_ACTIVE : `LIGHT_LOW);
    end
  endtask
  task t_lamps;
    begin
      lamps(3'b100);
      temperature = 16'h0023;
      lamps(3'b010);
      wr(`REG_SOURCE_SELECT, `SRC_HUMIDITY);
      lamps(3'b100);
      humidity_channel = 16'h0046;
      lamps(3'b010);
      wr(`REG_SOURCE_SELECT, 16'h0000);
      temperature = 16'h003C;
      lamps(3'b001);
    end
  endtask
  task t_blink;
    begin
      temperature = 16'h0023;
      wr(`REG_COMM_TIMEOUT, 16'h0001);
      repeat (15) @(posedge sys_clk);
      watch(16);
      chk("yblink", cy, 16'h0008);
      wr(`REG_COMM_TIMEOUT, 16'h0000);
      lamps(3'b010);
      temperature = 16'h003C;
      sensor_lost = 1'b1;
      watch(16);
      chk("rblink", cr, 16'h0008);
      sensor_lost = 1'b0;
      temperature = 16'h0019;
      bootloader_mode = 1'b1;
      // let the red out-of-range lamp drain through the two-cycle lamp path
      repeat (2) @(posedge sys_clk);
      watch(16);
      chk("gboot", cg, 16'h0008);
      chk("yboot", cy, 16'h0008);
      chk("both", cb, 16'h0000);
      chk("rboot", cr, 16'h0000);
      fw_downloading = 1'b1;
      watch(16);
      chk("rdown", cr, 16'h0008);
      bootloader_mode = 1'b0;
      fw_downloading = 1'b0;
    end
  endtask
  task t_bright;
    begin
      wr(`REG_BRIGHTNESS, 16'h0000);
      // pwm and lamp registers need two edges to show the new level
      repeat (3) @(posedge sys_clk);
      watch(20);
      chk("dark", cg, 16'h0000);
      wr(`REG_BRIGHTNESS, 16'h0005);
      repeat (3) @(posedge sys_clk);
      watch(20);
      chk("half", cg, 16'h000A);
    end
  endtask
  task t_misc;
    begin
      hum_channel_on = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk("demand", analog_demand, 16'h0010);
      wr(`REG_TERM_ENABLE, 16'h0001);
      @(posedge sys_clk);
      #1 chk("term", {15'h0000, bus_terminator_enable}, 16'h0001);
    end
  endtask
  task close_out;
    begin
      if (n_errors == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_regs;
    t_light;
    t_lamps;
    t_blink;
    t_bright;
    t_misc;
    close_out;
  end
endmodule // room_sensor_status_indication_tb_top
